// File: logic/uart_device.sv
// enhanced serial port: nine-bit modes, baud select, break, double buffer
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
module uart_device (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    input  wire logic       timer1_overflow,
    output logic [7:0]      rdata,
    output logic            break_reset,
    serial_link_if.device   link
);
    typedef struct packed {
        logic [1:0]          mode;
        logic                fe_view;
        logic                ren;
        logic                tb8;
        logic                rb8;
        logic                ti;
        logic                ri;
        logic                baud_double_sel;
        logic                brg_sel;
        logic                dben;
        logic                brk_rst_en;
        logic                fe;
        logic                brk;
        logic [15:0]         div;
        logic [15:0]         brg_cnt;
        logic                t1_half;
        logic                half2;
        logic [7:0]          rxbuf;
        logic [8:0]          hold;
        logic                hold_full;
        logic                tx_busy;
        logic                rx0;
        logic [10:0]         tx_sh;
        logic [3:0]          tx_cnt;
        logic [3:0]          tx_pre;
        uart_pkg::rx_state_t rx_st;
        logic [8:0]          rx_sh;
        logic [3:0]          rx_cnt;
        logic [3:0]          rx_pre;
        logic [3:0]          brk_pre;
        logic [3:0]          low_cnt;
        logic [7:0]          rdata;
        logic                txd;
        logic                rxd_out;
        logic                rxd_oe;
        logic                brk_pulse;
    } state_t;

    state_t s_reg;
    state_t s_next;

    always_comb
    begin
        logic       brg_tick;
        logic       tick;
        logic       shift_mode;
        logic       frame_end;
        logic [3:0] last;
        logic [3:0] idx;
        logic [10:0] shifted;
        brg_tick   = 1'b0;
        tick       = 1'b0;
        frame_end  = 1'b0;
        shift_mode = (s_reg.mode == uart_pkg::MODE_SHIFT);
        last       = shift_mode ? uart_pkg::LAST_MODE0
                   : (s_reg.mode == uart_pkg::MODE_TEN) ? uart_pkg::LAST_TEN
                   : uart_pkg::LAST_ELEV;
        idx        = s_reg.tx_cnt + 1'b1;
        shifted    = {1'b1, s_reg.tx_sh[10:1]};
        s_next     = s_reg;
        s_next.brk_pulse = 1'b0;

        // baud generator on the oscillator clock, timer 1 left free
        s_next.brg_cnt = s_reg.brg_cnt + 1'b1;
        if (s_reg.brg_cnt >= s_reg.div)
        begin
            brg_tick       = 1'b1;
            s_next.brg_cnt = 16'h0000;
        end
        s_next.half2 = !s_reg.half2;
        if (timer1_overflow)
            s_next.t1_half = !s_reg.t1_half;
        // sixteen sample ticks make one bit in every mode
        if (shift_mode)
            tick = 1'b1; // clock/16 bit rate
        else if (s_reg.mode == uart_pkg::MODE_FIXED)
            tick = s_reg.baud_double_sel || s_reg.half2; // /16 or /32
        else if (s_reg.brg_sel)
            tick = brg_tick; // mode 1 and 3 variable rate
        else
            tick = timer1_overflow && (s_reg.baud_double_sel || s_reg.t1_half);

        // configuration writes and flag clears, before hardware sets
        if (wr_en)
        begin
            if (addr == uart_pkg::OFS_CONTROL)
            begin
                if (s_reg.fe_view)
                    s_next.fe = s_reg.fe && wdata[uart_pkg::CTL_MODE_HI];
                else
                    s_next.mode[1] = wdata[uart_pkg::CTL_MODE_HI];
                s_next.mode[0] = wdata[uart_pkg::CTL_MODE_LO];
                s_next.ren     = wdata[uart_pkg::CTL_RX_EN];
                s_next.tb8     = wdata[uart_pkg::CTL_TX_NINE];
                s_next.rb8     = wdata[uart_pkg::CTL_RX_NINE];
                s_next.ti      = s_reg.ti && wdata[uart_pkg::CTL_TX_FLAG];
                s_next.ri      = s_reg.ri && wdata[uart_pkg::CTL_RX_FLAG];
                // mode 0 receive starts when enabled with flag clear
                if (shift_mode && !s_reg.tx_busy
                    && wdata[uart_pkg::CTL_RX_EN]
                    && !wdata[uart_pkg::CTL_RX_FLAG])
                begin
                    s_next.tx_busy = 1'b1;
                    s_next.rx0     = 1'b1;
                    s_next.tx_pre  = 4'h0;
                    s_next.tx_cnt  = 4'h0;
                    s_next.txd     = 1'b0;
                end
            end
            else if (addr == uart_pkg::OFS_POWER)
            begin
                s_next.baud_double_sel   = wdata[uart_pkg::PWR_BAUD_DBL];
                s_next.fe_view = wdata[uart_pkg::PWR_FE_VIEW];
            end
            else if (addr == uart_pkg::OFS_STATUS)
            begin
                s_next.dben       = wdata[uart_pkg::STA_DBUF_EN];
                s_next.brg_sel    = wdata[uart_pkg::STA_BRG_SEL];
                s_next.brk_rst_en = wdata[uart_pkg::STA_BRK_RST];
                s_next.brk = s_reg.brk && wdata[uart_pkg::STA_BREAK];
                s_next.fe  = s_reg.fe && wdata[uart_pkg::STA_FRAME];
            end
            else if (addr == uart_pkg::OFS_DIV_LO)
                s_next.div[7:0] = wdata;
            else if (addr == uart_pkg::OFS_DIV_HI)
                s_next.div[15:8] = wdata;
        end

        // transmit / mode 0 shift engine
        if (s_reg.tx_busy && tick)
        begin
            s_next.tx_pre = s_reg.tx_pre + 1'b1;
            if (shift_mode && s_reg.tx_pre == uart_pkg::SAMPLE_POINT)
            begin
                s_next.txd = 1'b1; // shift clock rises mid bit
                if (s_reg.rx0)
                    s_next.rx_sh = {1'b0, link.rxd, s_reg.rx_sh[7:1]};
            end
            if (s_reg.tx_pre == uart_pkg::TICK_LAST)
            begin
                s_next.tx_cnt  = idx;
                s_next.tx_sh   = shifted;
                s_next.rxd_out = shifted[0];
                if (shift_mode)
                    s_next.txd = 1'b0;
                else if (idx == uart_pkg::NINTH_IDX
                         && s_reg.mode == uart_pkg::MODE_TEN)
                    // ten-bit frame: slot nine is the stop bit, not tb8
                    s_next.txd = 1'b1;
                else if (idx == uart_pkg::NINTH_IDX
                         && s_reg.mode != uart_pkg::MODE_TEN)
                    // unbuffered: live bit; buffered: captured copy
                    s_next.txd = s_reg.dben ? shifted[0] : s_reg.tb8;
                else
                    s_next.txd = shifted[0]; // LSB first then stop
                if (s_reg.tx_cnt == last)
                begin
                    frame_end      = 1'b1;
                    s_next.tx_busy = 1'b0;
                    s_next.rx0     = 1'b0;
                    s_next.rxd_oe  = 1'b0;
                    s_next.txd     = 1'b1;
                    if (s_reg.rx0)
                    begin
                        s_next.rxbuf = s_reg.rx_sh[7:0];
                        s_next.ri    = 1'b1;
                    end
                    else if (!s_reg.dben || shift_mode)
                        s_next.ti = 1'b1; // end of shifting
                end
            end
        end
        // load from holding buffer, straight after a stop bit
        if (s_reg.hold_full && (!s_reg.tx_busy || frame_end)
            && !(s_reg.tx_busy && s_reg.rx0))
        begin
            s_next.tx_busy   = 1'b1;
            s_next.rx0       = 1'b0;
            s_next.hold_full = 1'b0;
            s_next.tx_pre    = 4'h0;
            s_next.tx_cnt    = 4'h0;
            if (shift_mode)
            begin
                s_next.tx_sh   = {3'h7, s_reg.hold[7:0]};
                s_next.rxd_out = s_reg.hold[0];
                s_next.rxd_oe  = 1'b1;
                s_next.txd     = 1'b0;
            end
            else
            begin
                s_next.tx_sh = {1'b1, s_reg.hold, 1'b0};
                s_next.txd   = 1'b0; // start bit
                if (s_reg.dben)
                    s_next.ti = 1'b1; // holding buffer free again
            end
        end

        // frame receiver for modes 1 to 3
        if (tick && s_reg.ren && !shift_mode)
        begin
            case (s_reg.rx_st)
                uart_pkg::RX_IDLE:
                begin
                    if (!link.rxd)
                    begin
                        s_next.rx_st  = uart_pkg::RX_BITS;
                        s_next.rx_pre = 4'h0;
                        s_next.rx_cnt = 4'h0;
                    end
                end
                default:
                begin
                    s_next.rx_pre = s_reg.rx_pre + 1'b1;
                    if (s_reg.rx_pre == uart_pkg::SAMPLE_POINT)
                    begin
                        s_next.rx_cnt = s_reg.rx_cnt + 1'b1;
                        if (s_reg.rx_cnt == 4'h0 && link.rxd)
                            s_next.rx_st = uart_pkg::RX_IDLE;
                        else if (s_reg.rx_cnt == last)
                        begin
                            s_next.rx_st = uart_pkg::RX_IDLE;
                            s_next.ri    = 1'b1;
                            if (!link.rxd)
                                s_next.fe = 1'b1;
                            if (s_reg.mode == uart_pkg::MODE_TEN)
                            begin
                                s_next.rxbuf = s_reg.rx_sh[8:1];
                                s_next.rb8   = link.rxd; // stop kept
                            end
                            else
                            begin
                                s_next.rxbuf = s_reg.rx_sh[7:0];
                                s_next.rb8   = s_reg.rx_sh[8];
                            end
                        end
                        else if (s_reg.rx_cnt != 4'h0)
                            s_next.rx_sh = {link.rxd, s_reg.rx_sh[8:1]};
                    end
                end
            endcase
        end

        // break: count low mid-bit samples, any high clears
        if (tick && !shift_mode)
        begin
            s_next.brk_pre = s_reg.brk_pre + 1'b1;
            if (s_reg.brk_pre == uart_pkg::SAMPLE_POINT)
            begin
                if (link.rxd)
                    s_next.low_cnt = 4'h0;
                else if (s_reg.low_cnt < uart_pkg::BREAK_BITS)
                begin
                    s_next.low_cnt = s_reg.low_cnt + 1'b1;
                    if (s_reg.low_cnt == uart_pkg::BREAK_BITS - 4'h1)
                    begin
                        s_next.brk       = 1'b1;
                        s_next.brk_pulse = s_reg.brk_rst_en;
                    end
                end
            end
        end

        // buffer write captures the ninth bit with the data
        if (wr_en && addr == uart_pkg::OFS_BUFFER)
        begin
            s_next.hold      = {s_reg.tb8, wdata};
            s_next.hold_full = 1'b1;
        end

        // read data stands in the cycle after the strobe
        s_next.rdata = uart_pkg::RESET_BYTE;
        if (rd_en)
        begin
            if (addr == uart_pkg::OFS_CONTROL)
                s_next.rdata = {s_reg.fe_view ? s_reg.fe : s_reg.mode[1],
                                s_reg.mode[0], 1'b0, s_reg.ren, s_reg.tb8,
                                s_reg.rb8, s_reg.ti, s_reg.ri};
            else if (addr == uart_pkg::OFS_BUFFER)
                s_next.rdata = s_reg.rxbuf;
            else if (addr == uart_pkg::OFS_POWER)
                s_next.rdata = {s_reg.baud_double_sel, s_reg.fe_view, 6'h00};
            else if (addr == uart_pkg::OFS_STATUS)
                s_next.rdata = {s_reg.dben, s_reg.brg_sel, s_reg.brk_rst_en,
                                3'h0, s_reg.brk, s_reg.fe};
            else if (addr == uart_pkg::OFS_DIV_LO)
                s_next.rdata = s_reg.div[7:0];
            else if (addr == uart_pkg::OFS_DIV_HI)
                s_next.rdata = s_reg.div[15:8];
        end
    end

    // single state register; idle lines high after reset
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            s_reg         <= '0;
            s_reg.div     <= uart_pkg::RESET_DIV;
            s_reg.txd     <= 1'b1;
            s_reg.rxd_out <= 1'b1;
        end
        else
            s_reg <= s_next;
    end

    assign rdata            = s_reg.rdata;
    assign break_reset      = s_reg.brk_pulse;
    assign link.txd         = s_reg.txd;
    assign link.dev_rxd_out = s_reg.rxd_out;
    assign link.dev_rxd_oe  = s_reg.rxd_oe;
endmodule

// File: logic/uart_peer.sv
// remote serial peer: one framed transmitter and one receiver
`timescale 1ns/1ns
module uart_peer #(
    parameter int BIT_CLKS = uart_pkg::PEER_BIT_CLKS
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       nine_bit,
    input  wire logic       send_valid,
    input  wire logic [8:0] send_data,
    input  wire logic       send_break,
    output logic            send_ready,
    output logic            recv_valid,
    output logic [8:0]      recv_data,
    output logic            recv_frame_err,
    serial_link_if.peer     link
);
    localparam int CW = $clog2(BIT_CLKS);
    localparam logic [CW-1:0] CLK_LAST = CW'(BIT_CLKS - 1);
    localparam logic [CW-1:0] CLK_MID  = CW'(BIT_CLKS / 2);

    typedef struct packed {
        logic [8:0]          hold;
        logic                hold_full;
        logic                tx_busy;
        logic [10:0]         tx_sh;
        logic [3:0]          tx_cnt;
        logic [CW-1:0]       tx_clk;
        logic                line;
        uart_pkg::rx_state_t rx_st;
        logic [8:0]          rx_sh;
        logic [3:0]          rx_cnt;
        logic [CW-1:0]       rx_clk;
        logic                rx_valid;
        logic [8:0]          rx_data;
        logic                rx_err;
    } state_t;

    state_t s_reg;
    state_t s_next;

    always_comb
    begin
        logic [3:0] last;
        logic       frame_end;
        last      = nine_bit ? uart_pkg::LAST_ELEV : uart_pkg::LAST_TEN;
        frame_end = 1'b0;
        s_next    = s_reg;
        s_next.rx_valid = 1'b0;
        // transmit: shift one bit per bit period, stop bit last
        if (s_reg.tx_busy)
        begin
            s_next.tx_clk = s_reg.tx_clk + 1'b1;
            if (s_reg.tx_clk == CLK_LAST)
            begin
                s_next.tx_clk = '0;
                s_next.tx_cnt = s_reg.tx_cnt + 1'b1;
                s_next.tx_sh  = {1'b1, s_reg.tx_sh[10:1]};
                s_next.line   = s_reg.tx_sh[1];
                if (s_reg.tx_cnt == last)
                begin
                    frame_end      = 1'b1;
                    s_next.tx_busy = 1'b0;
                    s_next.line    = 1'b1;
                end
            end
        end
        // next frame follows the stop bit directly when held
        if (s_reg.hold_full && (!s_reg.tx_busy || frame_end))
        begin
            s_next.tx_busy   = 1'b1;
            s_next.hold_full = 1'b0;
            s_next.tx_clk    = '0;
            s_next.tx_cnt    = 4'h0;
            s_next.line      = 1'b0;
            s_next.tx_sh     = nine_bit ? {1'b1, s_reg.hold, 1'b0}
                                        : {2'b11, s_reg.hold[7:0], 1'b0};
        end
        if (send_valid && !s_reg.hold_full)
        begin
            s_next.hold      = send_data;
            s_next.hold_full = 1'b1;
        end
        // receive: start on low line, sample each bit mid period
        case (s_reg.rx_st)
            uart_pkg::RX_IDLE:
            begin
                if (!link.txd)
                begin
                    s_next.rx_st  = uart_pkg::RX_BITS;
                    s_next.rx_clk = '0;
                    s_next.rx_cnt = 4'h0;
                end
            end
            default:
            begin
                s_next.rx_clk = (s_reg.rx_clk == CLK_LAST) ? '0
                                : s_reg.rx_clk + 1'b1;
                if (s_reg.rx_clk == CLK_MID)
                begin
                    s_next.rx_cnt = s_reg.rx_cnt + 1'b1;
                    if (s_reg.rx_cnt == 4'h0 && link.txd)
                        s_next.rx_st = uart_pkg::RX_IDLE; // false start
                    else if (s_reg.rx_cnt == last)
                    begin
                        s_next.rx_st    = uart_pkg::RX_IDLE;
                        s_next.rx_valid = 1'b1;
                        s_next.rx_err   = !link.txd;
                        // ten-bit frame keeps its stop bit as bit 8
                        s_next.rx_data  = nine_bit ? s_reg.rx_sh
                                          : {link.txd, s_reg.rx_sh[8:1]};
                    end
                    else if (s_reg.rx_cnt != 4'h0)
                        s_next.rx_sh = {link.txd, s_reg.rx_sh[8:1]};
                end
            end
        endcase
    end

    // single state register, synchronous active-low reset
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            s_reg      <= '0;
            s_reg.line <= 1'b1;
        end
        else
            s_reg <= s_next;
    end

    // break holds the line low regardless of the frame in progress
    logic brk_reg;
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            brk_reg <= 1'b0;
        else
            brk_reg <= send_break;
    end

    assign link.peer_rxd_out = s_reg.line && !brk_reg;
    assign send_ready        = !s_reg.hold_full;
    assign recv_valid        = s_reg.rx_valid;
    assign recv_data         = s_reg.rx_data;
    assign recv_frame_err    = s_reg.rx_err;
endmodule

// File: shared/serial_link_if.sv
// serial line between the device and the remote peer
`timescale 1ns/1ns
interface serial_link_if;
    logic txd;          // device transmit line, shift clock in mode 0
    logic dev_rxd_out;  // device drive of the receive line (mode 0)
    logic dev_rxd_oe;   // high while the device drives the receive line
    logic peer_rxd_out; // peer transmit, idles high
    logic rxd;          // resolved receive line
    // device drive wins while enabled, the peer otherwise
    assign rxd = dev_rxd_oe ? dev_rxd_out : peer_rxd_out;
    modport device (output txd, output dev_rxd_out, output dev_rxd_oe,
                    input rxd);
    modport peer (input txd, output peer_rxd_out, input rxd);
endinterface

// File: shared/uart_pkg.sv
// constants, offsets and types shared by both ends of the serial port
package uart_pkg;
    // register offsets on the software port
    localparam logic [2:0] OFS_CONTROL  = 3'h0;
    localparam logic [2:0] OFS_BUFFER   = 3'h1;
    localparam logic [2:0] OFS_POWER    = 3'h2;
    localparam logic [2:0] OFS_STATUS   = 3'h3;
    localparam logic [2:0] OFS_DIV_LO   = 3'h4;
    localparam logic [2:0] OFS_DIV_HI   = 3'h5;
    // serial_control_reg fields
    localparam int CTL_MODE_HI = 7;
    localparam int CTL_MODE_LO = 6;
    localparam int CTL_RX_EN   = 4;
    localparam int CTL_TX_NINE = 3;
    localparam int CTL_RX_NINE = 2;
    localparam int CTL_TX_FLAG = 1;
    localparam int CTL_RX_FLAG = 0;
    // power_control_reg fields
    localparam int PWR_BAUD_DBL = 7;
    localparam int PWR_FE_VIEW  = 6;
    // serial_status_reg fields
    localparam int STA_DBUF_EN  = 7;
    localparam int STA_BRG_SEL  = 6;
    localparam int STA_BRK_RST  = 5;
    localparam int STA_BREAK    = 1;
    localparam int STA_FRAME    = 0;
    // reset values
    localparam logic [7:0]  RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_DIV  = 16'h0000;
    // timing: sample ticks per bit, mid-bit sample point, break length
    localparam logic [3:0] TICK_LAST    = 4'hf;
    localparam logic [3:0] SAMPLE_POINT = 4'h7;
    localparam logic [3:0] BREAK_BITS   = 4'hb;
    // index of the last bit of each frame kind and of the ninth bit, start bit is index 0 (mode 0 has none)
    localparam logic [3:0] LAST_MODE0 = 4'h7;
    localparam logic [3:0] LAST_TEN   = 4'h9;
    localparam logic [3:0] LAST_ELEV  = 4'ha;
    localparam logic [3:0] NINTH_IDX  = 4'h9;
    // operating modes as held in the two mode select bits
    localparam logic [1:0] MODE_SHIFT = 2'h0;
    localparam logic [1:0] MODE_TEN   = 2'h1;
    localparam logic [1:0] MODE_FIXED = 2'h2;
    localparam logic [1:0] MODE_VAR   = 2'h3;
    // peer bit period in clocks
    localparam int PEER_BIT_CLKS = 32;
    typedef enum logic [0:0] {RX_IDLE, RX_BITS} rx_state_t;
endpackage

// File: testbench/tb_enhanced_uart_nine_bit_dbuf.sv
// self-checking bench: device and peer joined over the serial link
`timescale 1ns/1ns
module tb_enhanced_uart_nine_bit_dbuf;
    logic       clk = 1'b0, reset_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
    logic       timer1_overflow = 1'b0, nine_bit = 1'b0, send_valid = 1'b0;
    logic       send_break = 1'b0, break_reset, send_ready, recv_valid, fe;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, rdata, v;
    logic [8:0] send_data = 9'h000, recv_data;
    int         bad_count = 0, n_checks = 0, cyc = 0, n;
    serial_link_if serial_link_if_inst ();
    uart_device uart_device_inst (.clk(clk), .reset_n(reset_n), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .timer1_overflow(timer1_overflow), .break_reset(break_reset),
        .link(serial_link_if_inst));
    // sixteen clocks per bit matches mode 2 with the rate doubled
    uart_peer #(.BIT_CLKS(16)) uart_peer_inst (.clk(clk), .reset_n(reset_n),
        .nine_bit(nine_bit), .send_valid(send_valid), .send_data(send_data),
        .send_break(send_break), .send_ready(send_ready), .recv_data(recv_data),
        .recv_valid(recv_valid), .recv_frame_err(fe),
        .link(serial_link_if_inst));
    uart_link_asserts uart_link_asserts_inst (.clk(clk), .reset_n(reset_n),
        .txd(serial_link_if_inst.txd), .rxd(serial_link_if_inst.rxd),
        .dev_rxd_out(serial_link_if_inst.dev_rxd_out),
        .dev_rxd_oe(serial_link_if_inst.dev_rxd_oe),
        .peer_rxd_out(serial_link_if_inst.peer_rxd_out));
    initial
    begin
        forever #50 clk = ~clk;
    end
    task wrap_up;
        if (bad_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // bound on a hung frame
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            wrap_up;
        end
    end
    task chk(input string what, input logic [8:0] e, input logic [8:0] g);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task wait_recv(output int c);
        c = 0;
        while (recv_valid !== 1'b1 && c < 400)
        begin
            @(negedge clk);
            c++;
        end
        @(negedge clk);
    endtask
    task t_tx(input logic [1:0] m, input logic nb, input logic [7:0] st);
        repeat (16) @(posedge clk);
        nine_bit <= m[1];
        wr(uart_pkg::OFS_STATUS, st);
        wr(uart_pkg::OFS_CONTROL, {m, 2'b00, nb, 3'b000});
        wr(uart_pkg::OFS_BUFFER, 8'ha5);
        wait_recv(n);
        chk("peer data", {m[1] ? nb : 1'b1, 8'ha5}, recv_data);
        chk("peer frame", 9'h000, {8'h00, fe});
    endtask
    task t_rx;
        wr(uart_pkg::OFS_CONTROL, 8'h90);
        send_data <= 9'h15a;
        send_valid <= 1'b1;
        do @(posedge clk); while (send_ready !== 1'b1);
        send_valid <= 1'b0;
        v = 8'h00;
        for (n = 0; v[0] !== 1'b1 && n < 300; n++) rd(3'h0, v);
        chk("rx ninth", 9'h001, {8'h00, v[2]});
        rd(uart_pkg::OFS_BUFFER, v);
        chk("rx byte", 9'h05a, {1'b0, v});
    endtask
    task t_brk;
        wr(uart_pkg::OFS_STATUS, 8'h20);
        send_break <= 1'b1;
        for (n = 0; break_reset !== 1'b1 && n < 400; n++) @(negedge clk);
        chk("break delay", 9'h001, {8'h00, n >= 160 && n <= 200});
        @(posedge clk);
        send_break <= 1'b0;
        rd(uart_pkg::OFS_STATUS, v);
        chk("break flag", 9'h001, {8'h00, v[1]});
        // the break frame ends with a low stop bit: framing flag shown
        wr(uart_pkg::OFS_POWER, 8'hc0);
        rd(uart_pkg::OFS_CONTROL, v);
        chk("frame view", 9'h001, {8'h00, v[7]});
        wr(uart_pkg::OFS_POWER, 8'h80); // modes set with view off
        wr(uart_pkg::OFS_STATUS, 8'h00);
    endtask
    // second character queued while the first shifts, other ninth bit
    task t_dbuf;
        repeat (40) @(posedge clk);
        wr(uart_pkg::OFS_STATUS, 8'hc0);
        wr(uart_pkg::OFS_CONTROL, 8'h80);
        wr(uart_pkg::OFS_BUFFER, 8'h11);
        repeat (2) @(posedge clk);
        rd(uart_pkg::OFS_CONTROL, v);
        chk("tx flag", 9'h001, {8'h00, v[1]});
        wr(uart_pkg::OFS_CONTROL, 8'h88);
        wr(uart_pkg::OFS_BUFFER, 8'h22);
        wr(uart_pkg::OFS_CONTROL, 8'h80);
        wait_recv(n);
        chk("first", 9'h011, recv_data);
        wait_recv(n);
        chk("second", 9'h122, recv_data);
        chk("gap", 9'h0b0, 9'(n + 1));
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        timer1_overflow <= 1'b1;
        rd(uart_pkg::OFS_STATUS, v);
        chk("status reset", 9'h000, {1'b0, v});
        rd(3'h6, v);
        chk("unmapped", 9'h000, {1'b0, v});
        wr(uart_pkg::OFS_POWER, 8'h80); // framing view off
        // tb8 left alone until the frame is received
        t_tx(2'h1, 1'b0, 8'h40);
        t_tx(2'h2, 1'b0, 8'h00);
        t_tx(2'h3, 1'b1, 8'h40);
        t_tx(2'h3, 1'b0, 8'h00);
        t_rx;
        t_brk;
        t_dbuf;
        wr(uart_pkg::OFS_STATUS, 8'h00); // no double buffer in mode 0
        wr(uart_pkg::OFS_CONTROL, 8'h00);
        wr(uart_pkg::OFS_BUFFER, 8'h3c);
        repeat (160) @(posedge clk);
        wrap_up;
    end
endmodule

// File: testbench/uart_link_asserts.sv
// wire-level assertions on the serial link between the two ends
`timescale 1ns/1ns
module uart_link_asserts (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic txd,
    input wire logic dev_rxd_out,
    input wire logic dev_rxd_oe,
    input wire logic peer_rxd_out,
    input wire logic rxd
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // a bit is at least sixteen clocks, so eight is a safe floor
    sequence txd_low_run; !txd[*8]; endsequence
    sequence txd_high_run; txd[*8]; endsequence
    a_start_low: assert property ($fell(txd) |-> txd_low_run)
        else $error("txd low phase too short");
    a_stop_high: assert property ($rose(txd) |-> txd_high_run)
        else $error("txd high phase too short");
    a_shift_clock: assert property (dev_rxd_oe && $fell(txd) |-> ##8 txd)
        else $error("shift clock low phase not eight ticks");
    a_data_stable: assert property (dev_rxd_oe && !txd && $past(!txd)
        |-> $stable(dev_rxd_out)) else $error("shift data moved");
    a_oe_start: assert property ($rose(dev_rxd_oe) |-> ##[0:2] !txd)
        else $error("shift clock did not start");
    a_oe_hold: assert property ($rose(dev_rxd_oe) |-> dev_rxd_oe[*8])
        else $error("shift drive dropped early");
    a_peer_start: assert property ($fell(peer_rxd_out)
        |-> !peer_rxd_out[*8]) else $error("peer low too short");
    a_peer_stop: assert property ($rose(peer_rxd_out)
        |-> peer_rxd_out[*8]) else $error("peer high too short");
endmodule
